// ==== logic/disp_misc_regs.vh ====
// Register offsets, field positions and reset values of the display misc control bank.
// Assumes an 8-bit indexed index/data port pair driven by host I/O cycles on clk_i.
// How it works
// - ROM lock forces ROM select high on setup writes
// - Width field sets address counter modulus
// - Offset field adds to address bits 17:16
// - Odd/even page bit drives RAM address 0
// - Standard mapping overrides memory size setting
// - Palette lock blocks palette writes and strobe
// - Compat register writable only with lock 101
// - Compat register readable under four lock conditions
// - Mono compat blocks config port, forces status
// - Map-out bit hides ROM window, resets set
// - Free-running panel clock select bit
// - Passive colour depth select bit
// - Reverse video inverts nibbles, optionally text only
// - Highest contrast text intensity bit
// - Active-matrix select bit is write-only
// - Panel select field chooses timing parameter set
// - Frame pulse line select bit
// - CRT enable resets to one, selects timing
// - Panel enable resets zero, data stays active
// - Both enables force 8-dot and select low
// - Centering select zero, enable resets zero
// - Three-bit hsync delay in video clocks
// - Panel registers need unlock pattern 101XXXXX
`ifndef DISP_MISC_REGS_VH
`define DISP_MISC_REGS_VH
`define IDX_MISC_TWO 8'h2F
`define IDX_MISC_THREE 8'h30
`define IDX_PANEL_STATUS 8'h31
`define IDX_PANEL_CONTROL 8'h32
`define IDX_EXT_LOCK 8'h29
`define IDX_PANEL_UNLOCK 8'h34
`define IDX_MAP_UNLOCK 8'h35
`define IO_ROM_SETUP 16'h46E8
`define IO_PAL_LO 16'h03C6
`define IO_PAL_HI 16'h03C9
`define IO_MONO_CFG 16'h03BF
`define RST_MISC_TWO 8'h00
`define RST_MISC_THREE 8'h01
`define RST_PANEL_STATUS 8'h00
`define RST_PANEL_CONTROL 8'h20
`define RST_PANEL_UNLOCK 8'hA6
`define RST_ZERO 8'h00
`define B_ROM_LOCK 7
`define B_WIDTH_HI 6
`define B_WIDTH_LO 5
`define B_OFS_HI 4
`define B_OFS_LO 3
`define B_ODD_EVEN 2
`define B_VGA_MAP 1
`define B_PAL_LOCK 0
`define B_MONO 1
`define B_MAPOUT 0
`define B_FREE_CLK 6
`define B_DEPTH 5
`define B_REVERSE 4
`define B_CONTRAST 3
`define B_AMX 2
`define B_FP_LINE 6
`define B_CRT_EN 5
`define B_PANEL_EN 4
`define B_CTR_SEL 3
`define B_CTR_EN 2
`define B_HS_HI 7
`define MASK_STATUS_RD 8'h7B
`define MASK_THREE 8'h03
`define ULINE_MASK_MONO 8'h07
`define ULINE_MASK_STD 8'h77
`define ULINE_MATCH 8'h01
`define ROM_OUT_LO 20'hC6000
`define ROM_OUT_HI 20'hC67FF
`define CNT_64K 2'h1
`endif

// ==== logic/disp_misc_ctrl.v ====
// Indexed misc and flat panel control registers of a display controller.
// The bank holds the address counter options, the palette and ROM locks,
// the compatibility bits and the flat panel selection and timing bits.
// Assumes host I/O strobes are synchronous one-cycle pulses on clk_i.
// Assumes every level input already lives in the clk_i domain, so none is synchronised here.
`timescale 1ns/1ps
`default_nettype none
`include "disp_misc_regs.vh"
module disp_misc_ctrl
(
  input wire clk_i,
  input wire rst_n_i,
  // Raw host I/O cycles, one clock wide, used for the snooped ports.
  input wire io_wr_i,
  input wire io_rd_i,
  input wire [15:0] io_addr_i,
  // Index and data port pair through which software reaches the bank.
  input wire idx_wr_i,
  input wire [7:0] idx_i,
  input wire data_wr_i,
  input wire data_rd_i,
  input wire [7:0] data_i,
  // Mode levels from neighbouring register files and the sequencer.
  input wire [7:0] panel_option_reg_i,
  input wire odd_even_sel_i,
  input wire chain4_sel_i,
  input wire page_bit_i,
  input wire [1:0] memory_size_reg_i,
  // Address counter and host address levels, sampled every clock.
  input wire [17:0] disp_addr_i,
  input wire [19:0] mem_addr_i,
  input wire rom_access_i,
  // Pixel path levels that the compatibility and panel options modify.
  input wire [7:0] attr_i,
  input wire text_mode_i,
  input wire [3:0] upper_panel_nibble_i,
  input wire [3:0] lower_panel_nibble_i,
  input wire [7:0] status_i,
  // Sync timing; the delay line only advances on a video clock pulse.
  input wire hsync_i,
  input wire video_clock_en_i,
  // Every output is a flip-flop, so each follows its cause by one clock, except hsync_o, which adds the programmed video clock delay.
  output reg [7:0] data_o,
  output reg ext_rom_select_n_o,
  output reg palette_write_strobe_n_o,
  output reg palette_state_wr_o,
  output reg mono_cfg_wr_o,
  output reg [7:0] status_o,
  output reg underline_o,
  output reg rom_decline_o,
  // Memory addressing outputs.
  output reg [17:0] disp_addr_o,
  output reg ram_addr0_o,
  output reg ram_addr0_force_o,
  output reg std_map_o,
  // Flat panel and display device outputs.
  output reg [3:0] upper_panel_nibble_o,
  output reg [3:0] lower_panel_nibble_o,
  output reg free_clk_o,
  output reg depth_256k_o,
  output reg contrast_o,
  output reg amx_en_o,
  output reg [1:0] panel_select_field_o,
  output reg frame_pulse_line2_o,
  output reg crt_timing_o,
  output reg panel_en_o,
  output reg eight_dot_o,
  output reg display_kind_select_out_o,
  output reg center_en_o,
  output reg hsync_o
);
  reg [7:0] index_reg;
  reg [7:0] misc_two_reg;
  reg [7:0] misc_three_reg;
  reg [7:0] panel_status_reg;
  reg [7:0] panel_control_reg;
  reg [7:0] ext_lock_reg;
  reg [7:0] panel_unlock_reg;
  reg [7:0] map_unlock_reg;
  reg [7:0] hs_pipe_reg;
  reg [7:0] rd_next;
  wire panel_open;
  wire three_wr_ok;
  wire three_rd_ok;
  wire [2:0] hs_delay;
  wire both_en;
  wire [1:0] ca_sum;
  wire pal_hit;
  wire setup_hit;

  // Folds the start offset into the counter's upper bits. Counter bits above
  // the chosen modulus are masked first, so the count wraps inside its window
  // and the offset alone picks which 64K boundary the window starts on.
  function [1:0] page_base;
    input [1:0] count_hi;
    input [1:0] width;
    input [1:0] offset;
    reg [1:0] kept;
    begin
      kept = 2'h0;
      if (width[1])
        kept = 2'h0;
      else if (width[0])
        kept = {1'b0, count_hi[0]};
      else
        kept = count_hi;
      page_base = kept + offset;
    end
  endfunction

  // Unlock decodes shared by the read and write paths.
  // The lock registers themselves are always reachable, otherwise software
  // could never open the bank again after closing it.
  assign panel_open = (panel_unlock_reg[7:5] == 3'h5);
  assign three_wr_ok = (ext_lock_reg[2:0] == 3'h5);
  assign three_rd_ok = ext_lock_reg[7] && !ext_lock_reg[3] &&
    (panel_unlock_reg[7:5] != 3'h5) && (map_unlock_reg[6:4] != 3'h3);
  assign hs_delay = {panel_control_reg[`B_HS_HI], panel_control_reg[1:0]};
  assign both_en = panel_control_reg[`B_CRT_EN] && panel_control_reg[`B_PANEL_EN];
  assign ca_sum = page_base(disp_addr_i[17:16],
    {misc_two_reg[`B_WIDTH_HI], misc_two_reg[`B_WIDTH_LO]},
    {misc_two_reg[`B_OFS_HI], misc_two_reg[`B_OFS_LO]});

  // Host port decodes used by the strobe outputs below.
  assign pal_hit = io_wr_i && (io_addr_i >= `IO_PAL_LO) && (io_addr_i <= `IO_PAL_HI);
  assign setup_hit = io_wr_i && (io_addr_i == `IO_ROM_SETUP);

  // Index and register writes; panel registers are ignored while locked.
  // A data write in the same cycle as an index write still uses the old
  // index, since the index register only changes at the clock edge.
  // Refused writes give no indication on any port, as software expects.
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      index_reg <= `RST_ZERO;
      misc_two_reg <= `RST_MISC_TWO;
      misc_three_reg <= `RST_MISC_THREE;
      panel_status_reg <= `RST_PANEL_STATUS;
      panel_control_reg <= `RST_PANEL_CONTROL;
      ext_lock_reg <= `RST_ZERO;
      panel_unlock_reg <= `RST_PANEL_UNLOCK;
      map_unlock_reg <= `RST_ZERO;
    end
    else
    begin
      if (idx_wr_i)
      begin
        index_reg <= idx_i;
      end
      if (data_wr_i)
      begin
        case (index_reg)
          `IDX_MISC_TWO: misc_two_reg <= data_i;
          `IDX_MISC_THREE:
          begin
            if (three_wr_ok)
            begin
              misc_three_reg <= data_i & `MASK_THREE;
            end
          end
          `IDX_PANEL_STATUS:
          begin
            if (panel_open)
            begin
              panel_status_reg <= data_i;
            end
          end
          `IDX_PANEL_CONTROL:
          begin
            if (panel_open)
            begin
              // Centering select is reserved and held at auto-centering.
              panel_control_reg <= data_i & ~(8'h01 << `B_CTR_SEL);
            end
          end
          `IDX_EXT_LOCK: ext_lock_reg <= data_i;
          `IDX_PANEL_UNLOCK: panel_unlock_reg <= data_i;
          `IDX_MAP_UNLOCK: map_unlock_reg <= data_i;
          default:
          begin
            // Unmapped indexes are dropped; the index itself is left alone.
          end
        endcase
      end
    end
  end

  // Read mux; locked or unmapped indexes read zero.
  // Write-only bits are masked here rather than in storage, so the panel
  // interface keeps its setting while software sees a zero.
  always @*
  begin
    rd_next = `RST_ZERO;
    case (index_reg)
      `IDX_MISC_TWO: rd_next = misc_two_reg;
      `IDX_MISC_THREE: rd_next = three_rd_ok ? misc_three_reg : `RST_ZERO;
      `IDX_PANEL_STATUS:
        rd_next = panel_open ? (panel_status_reg & `MASK_STATUS_RD) : `RST_ZERO;
      `IDX_PANEL_CONTROL: rd_next = panel_open ? panel_control_reg : `RST_ZERO;
      `IDX_EXT_LOCK: rd_next = ext_lock_reg;
      `IDX_PANEL_UNLOCK: rd_next = panel_unlock_reg;
      `IDX_MAP_UNLOCK: rd_next = map_unlock_reg;
      default: rd_next = `RST_ZERO;
    endcase
  end

  // Horizontal sync delay line, advanced once per video clock enable.
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      hs_pipe_reg <= `RST_ZERO;
    end
    else if (video_clock_en_i)
    begin
      hs_pipe_reg <= {hs_pipe_reg[6:0], hsync_i};
    end
  end

  // Read data and host-side strobes.
  // Read data only moves on a data port read, so software may take it late
  // without racing a later index change.
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      data_o <= `RST_ZERO;
      ext_rom_select_n_o <= 1'b1;
      palette_write_strobe_n_o <= 1'b1;
      palette_state_wr_o <= 1'b0;
      mono_cfg_wr_o <= 1'b0;
    end
    else
    begin
      if (data_rd_i)
      begin
        data_o <= rd_next;
      end
      // The lock only masks the select pin; the internal setup copy lives
      // outside this block and is still loaded by the same write.
      ext_rom_select_n_o <= !(rom_access_i && !rom_decline_o) ||
        (misc_two_reg[`B_ROM_LOCK] && setup_hit);
      // A locked palette sees neither the strobe nor a state update.
      palette_write_strobe_n_o <= !(pal_hit && !misc_two_reg[`B_PAL_LOCK]);
      palette_state_wr_o <= pal_hit && !misc_two_reg[`B_PAL_LOCK];
      mono_cfg_wr_o <= io_wr_i && (io_addr_i == `IO_MONO_CFG) &&
        !misc_three_reg[`B_MONO];
    end
  end

  // Compatibility outputs.
  // The ROM window is only declined for a real ROM access, so an idle
  // address bus in the window never looks like a declined cycle.
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      status_o <= `RST_ZERO;
      underline_o <= 1'b0;
      rom_decline_o <= 1'b0;
    end
    else
    begin
      status_o <= misc_three_reg[`B_MONO] ? (status_i | 8'h80) : status_i;
      underline_o <= misc_three_reg[`B_MONO] ?
        ((attr_i & `ULINE_MASK_MONO) == `ULINE_MATCH) :
        ((attr_i & `ULINE_MASK_STD) == `ULINE_MATCH);
      rom_decline_o <= rom_access_i && misc_three_reg[`B_MAPOUT] &&
        (mem_addr_i >= `ROM_OUT_LO) && (mem_addr_i <= `ROM_OUT_HI);
    end
  end

  // Memory addressing outputs.
  // Width 1X keeps a 64K window, 01 a 128K window, 00 the full 256K count;
  // the masking is done in page_base before the offset is added.
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      disp_addr_o <= 18'h00000;
      ram_addr0_o <= 1'b0;
      ram_addr0_force_o <= 1'b0;
      std_map_o <= 1'b0;
    end
    else
    begin
      disp_addr_o <= {ca_sum, disp_addr_i[15:0]};
      ram_addr0_force_o <= misc_two_reg[`B_ODD_EVEN] && odd_even_sel_i &&
        !chain4_sel_i && !misc_two_reg[`B_VGA_MAP];
      ram_addr0_o <= page_bit_i;
      std_map_o <= misc_two_reg[`B_VGA_MAP] || (memory_size_reg_i == 2'h0);
    end
  end

  // Flat panel and display device outputs.
  // The nibbles stay live even with the panel off, since an external
  // palette may use them as pixel addresses.
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      upper_panel_nibble_o <= 4'h0;
      lower_panel_nibble_o <= 4'h0;
      free_clk_o <= 1'b0;
      depth_256k_o <= 1'b0;
      contrast_o <= 1'b0;
      amx_en_o <= 1'b0;
      panel_select_field_o <= 2'h0;
      frame_pulse_line2_o <= 1'b0;
      crt_timing_o <= 1'b1;
      panel_en_o <= 1'b0;
      eight_dot_o <= 1'b0;
      display_kind_select_out_o <= 1'b1;
      center_en_o <= 1'b0;
    end
    else
    begin
      // Graphics escapes inversion only when the panel option limits it to text.
      if (panel_status_reg[`B_REVERSE] && (text_mode_i || !panel_option_reg_i[3]))
      begin
        upper_panel_nibble_o <= ~upper_panel_nibble_i;
        lower_panel_nibble_o <= ~lower_panel_nibble_i;
      end
      else
      begin
        upper_panel_nibble_o <= upper_panel_nibble_i;
        lower_panel_nibble_o <= lower_panel_nibble_i;
      end
      free_clk_o <= panel_status_reg[`B_FREE_CLK];
      depth_256k_o <= panel_status_reg[`B_DEPTH];
      // Contrast boost only matters in text modes, so graphics never sees it.
      contrast_o <= panel_status_reg[`B_CONTRAST] && text_mode_i;
      amx_en_o <= panel_status_reg[`B_AMX];
      panel_select_field_o <= panel_status_reg[1:0];
      frame_pulse_line2_o <= panel_control_reg[`B_FP_LINE];
      crt_timing_o <= panel_control_reg[`B_CRT_EN];
      panel_en_o <= panel_control_reg[`B_PANEL_EN];
      eight_dot_o <= both_en;
      display_kind_select_out_o <= !both_en;
      center_en_o <= panel_control_reg[`B_CTR_EN];
    end
  end

  // Delayed horizontal sync output.
  // A zero delay passes the input through one register stage only, so the
  // delay counts are extra video clocks on top of the output flip-flop.
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      hsync_o <= 1'b0;
    end
    else
    begin
      hsync_o <= (hs_delay == 3'h0) ? hsync_i : hs_pipe_reg[hs_delay - 3'h1];
    end
  end
endmodule // disp_misc_ctrl
`default_nettype wire

// ==== dv/disp_misc_ctrl_monitor.sv ====
// Checker bound to disp_misc_ctrl, seeing only its ports.
// Assumes outputs are registered one clock after their causes.
`timescale 1ns/1ps
`default_nettype none
module disp_misc_ctrl_monitor
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic io_wr_i,
  input wire logic [15:0] io_addr_i,
  input wire logic data_rd_i,
  input wire logic [7:0] data_o,
  input wire logic [7:0] attr_i,
  input wire logic [19:0] mem_addr_i,
  input wire logic rom_access_i,
  input wire logic odd_even_sel_i,
  input wire logic chain4_sel_i,
  input wire logic page_bit_i,
  input wire logic palette_write_strobe_n_o,
  input wire logic mono_cfg_wr_o,
  input wire logic underline_o,
  input wire logic rom_decline_o,
  input wire logic ram_addr0_o,
  input wire logic ram_addr0_force_o,
  input wire logic crt_timing_o,
  input wire logic panel_en_o,
  input wire logic eight_dot_o,
  input wire logic display_kind_select_out_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // Each output but the dual display pair is tied to the input that caused it one cycle before.
  pal_strobe_a: assert property (
    !palette_write_strobe_n_o |-> $past(io_wr_i) && $past(io_addr_i) inside {[16'h03C6:16'h03C9]})
    else $error("palette strobe without palette write");
  mono_cfg_a: assert property (
    mono_cfg_wr_o |-> $past(io_wr_i) && $past(io_addr_i) == 16'h03BF)
    else $error("config write without port write");
  rom_window_a: assert property (
    rom_decline_o |-> $past(rom_access_i) && $past(mem_addr_i) inside {[20'hC6000:20'hC67FF]})
    else $error("ROM declined outside window");
  read_hold_a: assert property (
    $past(rst_n_i) && !$past(data_rd_i) |-> $stable(data_o))
    else $error("read data moved without a read");
  dual_display_a: assert property (
    crt_timing_o && panel_en_o |-> eight_dot_o && !display_kind_select_out_o)
    else $error("dual display not locked");
  page_cond_a: assert property (
    ram_addr0_force_o |-> $past(odd_even_sel_i) && !$past(chain4_sel_i))
    else $error("page bit forced in wrong mode");
  page_value_a: assert property (
    ram_addr0_force_o |-> ram_addr0_o == $past(page_bit_i))
    else $error("page bit not passed");
  underline_dec_a: assert property (
    underline_o |-> $past(attr_i[2:0]) == 3'h1)
    else $error("underline on wrong attribute");
endmodule // disp_misc_ctrl_monitor
bind disp_misc_ctrl disp_misc_ctrl_monitor mon (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .io_wr_i(io_wr_i), .io_addr_i(io_addr_i), .data_rd_i(data_rd_i), .data_o(data_o),
  .attr_i(attr_i), .mem_addr_i(mem_addr_i), .rom_access_i(rom_access_i),
  .odd_even_sel_i(odd_even_sel_i), .chain4_sel_i(chain4_sel_i), .page_bit_i(page_bit_i),
  .palette_write_strobe_n_o(palette_write_strobe_n_o), .mono_cfg_wr_o(mono_cfg_wr_o),
  .underline_o(underline_o), .rom_decline_o(rom_decline_o), .ram_addr0_o(ram_addr0_o),
  .ram_addr0_force_o(ram_addr0_force_o), .crt_timing_o(crt_timing_o), .panel_en_o(panel_en_o),
  .eight_dot_o(eight_dot_o), .display_kind_select_out_o(display_kind_select_out_o));
`default_nettype wire

// ==== dv/host_io_model.sv ====
// Host software model driving the index/data port pair and raw I/O writes.
// Assumes its tasks are called just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module host_io_model
(
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  output logic idx_wr_o = 1'b0,
  output logic [7:0] idx_o = 8'h00,
  output logic data_wr_o = 1'b0,
  output logic data_rd_o = 1'b0,
  output logic [7:0] data_o = 8'h00,
  output logic io_wr_o = 1'b0,
  output logic [15:0] io_addr_o = 16'h0000
);
  // The index always goes first; released index and data lines flip so stale data never looks valid.
  task automatic sel(input logic [7:0] i);
    idx_wr_o = 1'b1;
    idx_o = i;
    @(posedge clk_i);
    #1 idx_wr_o = 1'b0;
    idx_o = ~i;
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] v);
    sel(i);
    data_wr_o = 1'b1;
    data_o = v;
    @(posedge clk_i);
    #1 data_wr_o = 1'b0;
    data_o = ~v;
  endtask
  task automatic rd(input logic [7:0] i, output logic [7:0] v);
    sel(i);
    data_rd_o = 1'b1;
    @(posedge clk_i);
    #1 data_rd_o = 1'b0;
    @(posedge clk_i);
    #1 v = rdata_i;
  endtask
  task automatic io(input logic [15:0] a);
    io_wr_o = 1'b1;
    io_addr_o = a;
    @(posedge clk_i);
    #1 io_wr_o = 1'b0;
  endtask
endmodule // host_io_model
`default_nettype wire

// ==== dv/disp_misc_ctrl_bench.sv ====
// Self-checking bench for the display misc control bank.
// Assumes host_io_model and the bound checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "disp_misc_regs.vh"
module disp_misc_ctrl_bench;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic odd_i = 1'b0, ch4_i = 1'b0, page_i = 1'b0, rom_i = 1'b0, txt_i = 1'b0;
  logic [7:0] opt_i = 8'h00, attr_i = 8'h00, rd;
  logic [3:0] up_i = 4'h5, lo_i = 4'h3;
  logic [1:0] ms_i = 2'h1;
  logic hs_i = 1'b0, vce_i = 1'b0;
  logic [17:0] da_i = 18'h32345;
  logic [19:0] ma_i = 20'hC67FF;
  wire logic iw, dw, dr, iow;
  wire logic [7:0] idx, wd, data_o;
  wire logic [15:0] ioa;
  int bad_count = 0, compares = 0, cycles = 0;
  host_io_model h (.clk_i(clk_i), .rdata_i(data_o), .idx_wr_o(iw), .idx_o(idx), .data_wr_o(dw),
    .data_rd_o(dr), .data_o(wd), .io_wr_o(iow), .io_addr_o(ioa));
  disp_misc_ctrl dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .io_wr_i(iow), .io_rd_i(1'b0),
    .io_addr_i(ioa), .idx_wr_i(iw), .idx_i(idx), .data_wr_i(dw), .data_rd_i(dr), .data_i(wd),
    .panel_option_reg_i(opt_i), .odd_even_sel_i(odd_i), .chain4_sel_i(ch4_i),
    .page_bit_i(page_i), .memory_size_reg_i(ms_i), .disp_addr_i(da_i), .mem_addr_i(ma_i),
    .rom_access_i(rom_i), .attr_i(attr_i), .text_mode_i(txt_i), .upper_panel_nibble_i(up_i),
    .lower_panel_nibble_i(lo_i), .status_i(8'h00), .hsync_i(hs_i), .video_clock_en_i(vce_i),
    .data_o(data_o), .ext_rom_select_n_o(), .palette_write_strobe_n_o(), .palette_state_wr_o(),
    .mono_cfg_wr_o(), .status_o(), .underline_o(), .rom_decline_o(), .disp_addr_o(),
    .ram_addr0_o(), .ram_addr0_force_o(), .std_map_o(), .upper_panel_nibble_o(),
    .lower_panel_nibble_o(), .free_clk_o(), .depth_256k_o(), .contrast_o(), .amx_en_o(),
    .panel_select_field_o(), .frame_pulse_line2_o(), .crt_timing_o(), .panel_en_o(),
    .eight_dot_o(), .display_kind_select_out_o(), .center_en_o(), .hsync_o());
  // Half period of a 40 MHz clock.
  initial
  begin
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic end_sim();
    if (bad_count == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [17:0] a, input logic [17:0] e);
    compares++;
    if (a !== e)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t exp %h got %h", $time, e, a);
    end
  endtask
  // Outputs trail their causes by a register stage, so wait n edges, then 1 ns.
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // The sequence needs about a hundred cycles; this ceiling only cuts a hang.
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      bad_count++;
      end_sim();
    end
  end
  initial
  begin
    repeat (12) @(posedge clk_i);
    #1 rst_n_i = 1'b1;
    h.rd(`IDX_MISC_TWO, rd);
    chk(rd, 8'h00);
    h.rd(`IDX_PANEL_CONTROL, rd);
    chk(rd, 8'h20);
    chk(dut.panel_en_o, 1'b0);
    h.wr(`IDX_PANEL_CONTROL, 8'h3C);
    h.rd(`IDX_PANEL_CONTROL, rd);
    chk(rd, 8'h34);
    chk({dut.eight_dot_o, dut.display_kind_select_out_o, dut.center_en_o}, 3'h5);
    chk({dut.frame_pulse_line2_o, dut.crt_timing_o}, 2'h1);
    for (int i = 0; i < 4; i++)
    begin
      h.wr(`IDX_PANEL_STATUS, 8'h6C | 8'(i));
      h.rd(`IDX_PANEL_STATUS, rd);
      chk(rd, 8'h68 | 8'(i));
      chk({dut.free_clk_o, dut.depth_256k_o, dut.contrast_o, dut.amx_en_o}, 4'hD);
      chk(dut.panel_select_field_o, i[1:0]);
    end
    h.wr(`IDX_PANEL_STATUS, 8'h13);
    step(2);
    chk({dut.upper_panel_nibble_o, dut.lower_panel_nibble_o}, 8'hAC);
    opt_i = 8'h08;
    step(2);
    chk({dut.upper_panel_nibble_o, dut.lower_panel_nibble_o}, 8'h53);
    txt_i = 1'b1;
    h.wr(`IDX_PANEL_UNLOCK, 8'h00);
    h.wr(`IDX_PANEL_STATUS, 8'h00);
    h.rd(`IDX_PANEL_STATUS, rd);
    chk(rd, 8'h00);
    chk({dut.panel_select_field_o, dut.upper_panel_nibble_o}, 6'h3A);
    rom_i = 1'b1;
    step(2);
    chk(dut.rom_decline_o, 1'b1);
    h.wr(`IDX_MISC_THREE, 8'h02);
    h.io(`IO_MONO_CFG);
    chk(dut.mono_cfg_wr_o, 1'b1);
    h.wr(`IDX_EXT_LOCK, 8'h85);
    h.wr(`IDX_MISC_THREE, 8'h02);
    h.io(`IO_MONO_CFG);
    chk(dut.mono_cfg_wr_o, 1'b0);
    attr_i = 8'h09;
    step(2);
    chk({dut.underline_o, dut.rom_decline_o}, 2'h2);
    chk(dut.status_o, 8'h80);
    h.rd(`IDX_MISC_THREE, rd);
    chk(rd, 8'h02);
    h.wr(`IDX_PANEL_UNLOCK, 8'hA0);
    h.rd(`IDX_MISC_THREE, rd);
    chk(rd, 8'h00);
    h.io(`IO_PAL_HI);
    chk({dut.palette_write_strobe_n_o, dut.palette_state_wr_o}, 2'h1);
    h.wr(`IDX_MISC_TWO, 8'h81);
    h.io(`IO_PAL_HI);
    chk({dut.palette_write_strobe_n_o, dut.palette_state_wr_o}, 2'h2);
    h.io(`IO_ROM_SETUP);
    chk(dut.ext_rom_select_n_o, 1'b1);
    h.wr(`IDX_MISC_TWO, 8'h18);
    step(2);
    chk(dut.disp_addr_o, 18'h22345);
    odd_i = 1'b1;
    page_i = 1'b1;
    h.wr(`IDX_MISC_TWO, 8'h44);
    step(2);
    chk(dut.disp_addr_o, 18'h02345);
    chk({dut.ram_addr0_force_o, dut.ram_addr0_o}, 2'h3);
    chk(dut.std_map_o, 1'b0);
    h.rd(8'h40, rd);
    chk(rd, 8'h00);
    h.wr(`IDX_MISC_TWO, 8'h02);
    step(2);
    chk(dut.std_map_o, 1'b1);
    h.wr(`IDX_PANEL_CONTROL, 8'h01);
    vce_i = 1'b1;
    hs_i = 1'b1;
    step(1);
    chk(dut.hsync_o, 1'b0);
    step(1);
    chk(dut.hsync_o, 1'b1);
    end_sim();
  end
endmodule // disp_misc_ctrl_bench
`default_nettype wire
